// File: hw/csp_pkg.sv
// constants, encodings and timing shared by both ends of the camera serial register port
// assumes a 25 MHz pclk on both ends
package csp_pkg;

    // ------------------------------------------------------------
    // device address byte and register address byte layout
    // ------------------------------------------------------------
    localparam logic [4:0] DAB_FIXED    = 5'h11;
    localparam int         DAB_RW_BIT   = 0;
    localparam int         RAB_AUTO_BIT = 6;
    localparam logic [3:0] BYTE_BITS    = 4'h8;

    // ------------------------------------------------------------
    // pointer limits
    // ------------------------------------------------------------
    localparam logic [5:0] PTR_RELOAD  = 6'h26;
    localparam logic [5:0] PTR_RD_WRAP = 6'h2A;
    localparam logic [5:0] PTR_RESET   = 6'h00;

    // ------------------------------------------------------------
    // controller register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD      = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h04;
    localparam logic [7:0] OFS_DIV      = 8'h08;
    localparam int         CMD_OP_LSB   = 0;
    localparam int         CMD_NACK_BIT = 2;
    localparam int         CMD_DATA_LSB = 8;
    localparam int         STAT_BUSY    = 8;
    localparam int         STAT_NACK    = 9;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          PCLK_HZ     = 25_000_000;
    localparam int          BUS_RATE_HZ = 400_000;
    localparam int          QTR_CYC     = (PCLK_HZ + 4 * BUS_RATE_HZ - 1) / (4 * BUS_RATE_HZ);
    localparam logic [15:0] DIV_RESET   = 16'(QTR_CYC);
    localparam logic [15:0] DIV_MIN     = 16'h0004;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEVA = 3'b001,
        ST_REGA = 3'b010,
        ST_WDAT = 3'b011,
        ST_RDAT = 3'b100
    } csp_dev_st_e;

    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_STOP  = 2'b01,
        OP_WRITE = 2'b10,
        OP_READ  = 2'b11
    } csp_op_e;

endpackage : csp_pkg

// File: hw/csp_bus_if.sv
// two-wire link between controller and camera port
// assumes pull-ups: a line is high unless some party pulls it low
interface csp_bus_if;

    logic scl_o;
    logic scl_oe_n;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic scl;
    logic sda;

    // wired-AND of the open-drain drivers
    assign scl = scl_oe_n | scl_o;
    assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

    modport dev  (input scl, sda, output sda_s_o, sda_s_oe_n);
    modport host (input sda, output scl_o, scl_oe_n, sda_m_o, sda_m_oe_n);

endinterface : csp_bus_if

// File: hw/csp_dev.sv
// camera side of the two-wire register port: slave only
// assumes pclk far faster than the link clock, and a register file whose
// reg_rdata follows reg_addr combinationally
// Contract
// - link clock is input only; master clocks
// - lines are open-drain, wired-AND, idle high
// - handle 400kbit/s shared, 5 MHz direct
// - data fall with clock high starts
// - data changes only while clock low
// - data rise with clock high stops
// - device address 10001, ~pin, pin, direction
// - register byte: auto-step bit6, pointer bits5:0
// - direction 0 writes, 1 reads
// - pointer field loads pointer; access uses it
// - auto-step write: increment after storing
// - auto-step read: increment before load, not first
// - no auto-step write: pointer unchanged
// - no auto-step read: pointer unchanged
// - master clocks ack, releases data line
// - device acks every written byte low
// - alternating write: register byte before each data
// - auto write at 26 reloads pointer
// - stop or repeated start ends sequence
// - master nack ends read; device releases
// - read: address, register, restart, read address
// - auto read pointer wraps 2A to 00
module csp_dev (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // two-wire link
    csp_bus_if.dev           bus,
    // address strap
    input  wire logic        address_select_pin,
    // register file port
    output logic [5:0]       reg_addr,
    output logic             reg_wr,
    output logic [7:0]       reg_wdata,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]           scl_s;
        logic [1:0]           sda_s;
        logic [1:0]           as_s;
        logic                 scl_p;
        logic                 sda_p;
        csp_pkg::csp_dev_st_e st;
        logic                 ack;
        logic [3:0]           cnt;
        logic [7:0]           sh;
        logic [5:0]           ptr;
        logic                 auto_step;
        logic                 first;
        logic                 nack;
        logic                 load;
        logic                 oe_n;
        logic [5:0]           addr;
        logic                 wr;
        logic                 rd;
        logic [7:0]           wdata;
    } csp_dev_s;

    csp_dev_s q;
    csp_dev_s d;

    logic       scl_hi;
    logic       start_c;
    logic       stop_c;
    logic       rise;
    logic       fall;
    logic       strap;
    logic       match;
    logic [5:0] fetch;

    // ------------------------------------------------------------
    // pointer step for reads
    // ------------------------------------------------------------
    function automatic logic [5:0] csp_step(input logic [5:0] p);
        logic [5:0] r;
        r = (p == csp_pkg::PTR_RD_WRAP) ? csp_pkg::PTR_RESET : 6'(p + 6'h01);
        return r;
    endfunction : csp_step

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        d.wr    = 1'b0;
        d.rd    = 1'b0;
        // two-flop sampling of the master's clock and data; sampled
        // often enough for a 400 kHz link at 25 MHz pclk
        d.scl_s = {q.scl_s[0], bus.scl};
        d.sda_s = {q.sda_s[0], bus.sda};
        d.as_s  = {q.as_s[0], address_select_pin};
        d.scl_p = q.scl_s[1];
        d.sda_p = q.sda_s[1];
        scl_hi  = q.scl_s[1] & q.scl_p;
        start_c = scl_hi & q.sda_p & ~q.sda_s[1];
        stop_c  = scl_hi & ~q.sda_p & q.sda_s[1];
        rise    = q.scl_s[1] & ~q.scl_p;
        fall    = ~q.scl_s[1] & q.scl_p;
        strap   = q.as_s[1];
        match   = (q.sh[7:3] == csp_pkg::DAB_FIXED) && (q.sh[2] == ~strap)
                  && (q.sh[1] == strap);
        fetch   = (q.auto_step && !q.first) ? csp_step(q.ptr) : q.ptr;

        if (start_c) begin
            // a repeated start also ends any running sequence
            d.st   = csp_pkg::ST_DEVA;
            d.cnt  = 4'h0;
            d.ack  = 1'b0;
            d.load = 1'b0;
            d.oe_n = 1'b1;
        end else if (stop_c) begin
            d.st   = csp_pkg::ST_IDLE;
            d.ack  = 1'b0;
            d.load = 1'b0;
            d.oe_n = 1'b1;
        end else if (q.load) begin
            // reg_rdata now follows the fetch address
            d.load = 1'b0;
            d.sh   = {reg_rdata[6:0], 1'b0};
            d.oe_n = reg_rdata[7];
            d.cnt  = 4'h1;
        end else if (rise && q.st != csp_pkg::ST_IDLE) begin
            if (q.ack) begin
                if (q.st == csp_pkg::ST_RDAT) begin
                    d.nack = q.sda_s[1];
                end
            end else if (q.st != csp_pkg::ST_RDAT) begin
                d.sh  = {q.sh[6:0], q.sda_s[1]};
                d.cnt = 4'(q.cnt + 4'h1);
            end
        end else if (fall && q.st == csp_pkg::ST_RDAT) begin
            if (q.ack) begin
                d.ack = 1'b0;
                if (q.nack) begin
                    d.st = csp_pkg::ST_IDLE;
                end else begin
                    d.ptr   = fetch;
                    d.addr  = fetch;
                    d.first = 1'b0;
                    d.rd    = 1'b1;
                    d.load  = 1'b1;
                end
            end else if (q.cnt == csp_pkg::BYTE_BITS) begin
                d.ack  = 1'b1;
                d.oe_n = 1'b1;
            end else begin
                d.oe_n = q.sh[7];
                d.sh   = {q.sh[6:0], 1'b0};
                d.cnt  = 4'(q.cnt + 4'h1);
            end
        end else if (fall && q.st != csp_pkg::ST_IDLE) begin
            if (q.ack) begin
                // end of the acknowledge bit: release and pick the next byte
                d.ack  = 1'b0;
                d.oe_n = 1'b1;
                d.cnt  = 4'h0;
                case (q.st)
                    csp_pkg::ST_DEVA: begin
                        if (q.sh[csp_pkg::DAB_RW_BIT]) begin
                            d.st    = csp_pkg::ST_RDAT;
                            d.ptr   = fetch;
                            d.addr  = fetch;
                            d.first = 1'b0;
                            d.rd    = 1'b1;
                            d.load  = 1'b1;
                        end else begin
                            d.st = csp_pkg::ST_REGA;
                        end
                    end
                    csp_pkg::ST_REGA: begin
                        d.st = csp_pkg::ST_WDAT;
                    end
                    csp_pkg::ST_WDAT: begin
                        d.st = q.auto_step ? csp_pkg::ST_WDAT : csp_pkg::ST_REGA;
                    end
                    default: begin
                        d.st = csp_pkg::ST_IDLE;
                    end
                endcase
            end else if (q.cnt == csp_pkg::BYTE_BITS) begin
                // a full byte is in: drive the acknowledge low
                d.ack  = 1'b1;
                d.oe_n = 1'b0;
                case (q.st)
                    csp_pkg::ST_DEVA: begin
                        if (!match) begin
                            d.ack  = 1'b0;
                            d.oe_n = 1'b1;
                            d.st   = csp_pkg::ST_IDLE;
                        end
                    end
                    csp_pkg::ST_REGA: begin
                        d.auto_step = q.sh[csp_pkg::RAB_AUTO_BIT];
                        d.ptr       = q.sh[5:0];
                        d.first     = 1'b1;
                    end
                    csp_pkg::ST_WDAT: begin
                        if (q.auto_step && q.ptr == csp_pkg::PTR_RELOAD) begin
                            d.ptr = q.sh[5:0];
                        end else begin
                            d.wr    = 1'b1;
                            d.addr  = q.ptr;
                            d.wdata = q.sh;
                            if (q.auto_step) begin
                                d.ptr = 6'(q.ptr + 6'h01);
                            end else begin
                                d.ptr = q.ptr;
                            end
                        end
                    end
                    default: begin
                        d.st = csp_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.scl_s     <= 2'b11;
            q.sda_s     <= 2'b11;
            q.scl_p     <= 1'b1;
            q.sda_p     <= 1'b1;
            q.st        <= csp_pkg::ST_IDLE;
            q.ptr       <= csp_pkg::PTR_RESET;
            q.oe_n      <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.sda_s_o    = 1'b0;
    assign bus.sda_s_oe_n = q.oe_n;
    assign reg_addr       = q.addr;
    assign reg_wr         = q.wr;
    assign reg_wdata      = q.wdata;
    assign reg_rd         = q.rd;

endmodule : csp_dev

// File: hw/csp_host.sv
// controller side of the two-wire register port, driven by software over apb
// assumes apb master on pclk and the camera port on the far side of the link
module csp_host #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // two-wire link
    csp_bus_if.host                bus
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       sda_s;
        logic             busy;
        csp_pkg::csp_op_e op;
        logic [15:0]      div;
        logic [15:0]      cnt;
        logic [1:0]       ph;
        logic [3:0]       bitn;
        logic [8:0]       tx;
        logic [8:0]       rx;
        logic             scl_oe_n;
        logic             sda_oe_n;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } csp_host_s;

    csp_host_s q;
    csp_host_s d;

    logic       acc;
    logic       take;
    logic       tick;
    logic [7:0] ofs;
    logic       hit;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        d.sda_s = {q.sda_s[0], bus.sda};
        ofs     = 8'(paddr);
        hit     = (ofs == csp_pkg::OFS_CMD) || (ofs == csp_pkg::OFS_STAT)
                  || (ofs == csp_pkg::OFS_DIV);
        acc     = psel & penable;
        take    = acc & q.pready;
        tick    = q.busy && (q.cnt == 16'h0000);

        // one wait state, then the answer
        d.pready  = acc & ~q.pready;
        if (acc && !q.pready) begin
            d.pslverr = ~hit;
            d.prdata  = 32'h0000_0000;
            if (ofs == csp_pkg::OFS_STAT) begin
                d.prdata[7:0]               = q.rx[8:1];
                d.prdata[csp_pkg::STAT_BUSY] = q.busy;
                d.prdata[csp_pkg::STAT_NACK] = q.rx[0];
            end else if (ofs == csp_pkg::OFS_DIV) begin
                d.prdata[15:0] = q.div;
            end
        end
        if (take && pwrite) begin
            if (ofs == csp_pkg::OFS_CMD && !q.busy) begin
                d.busy = 1'b1;
                d.op   = csp_pkg::csp_op_e'(pwdata[csp_pkg::CMD_OP_LSB +: 2]);
                d.ph   = 2'b00;
                d.bitn = 4'h0;
                d.cnt  = q.div;
                d.tx   = (d.op == csp_pkg::OP_READ) ? {8'hFF, pwdata[csp_pkg::CMD_NACK_BIT]}
                                                    : {pwdata[csp_pkg::CMD_DATA_LSB +: 8], 1'b1};
            end else if (ofs == csp_pkg::OFS_DIV) begin
                d.div = (pwdata[15:0] < csp_pkg::DIV_MIN) ? csp_pkg::DIV_MIN : pwdata[15:0];
            end
        end

        // link sequencer: four quarter-bit phases per step
        if (q.busy) begin
            d.cnt = tick ? q.div : 16'(q.cnt - 16'h0001);
        end
        if (tick) begin
            d.ph = 2'(q.ph + 2'b01);
            case (q.op)
                csp_pkg::OP_START: begin
                    case (q.ph)
                        2'b00:   d.sda_oe_n = 1'b1;
                        2'b01:   d.scl_oe_n = 1'b1;
                        2'b10:   d.sda_oe_n = 1'b0;
                        default: begin
                            d.scl_oe_n = 1'b0;
                            d.busy     = 1'b0;
                        end
                    endcase
                end
                csp_pkg::OP_STOP: begin
                    case (q.ph)
                        2'b00:   d.sda_oe_n = 1'b0;
                        2'b01:   d.scl_oe_n = 1'b1;
                        2'b10:   d.sda_oe_n = 1'b1;
                        default: d.busy     = 1'b0;
                    endcase
                end
                default: begin
                    // data changes only with the clock low; the ninth bit
                    // releases the line for the camera ack on writes
                    case (q.ph)
                        2'b00:   d.sda_oe_n = q.tx[8];
                        2'b01:   d.scl_oe_n = 1'b1;
                        2'b10:   d.rx       = {q.rx[7:0], q.sda_s[1]};
                        default: begin
                            d.scl_oe_n = 1'b0;
                            d.tx       = {q.tx[7:0], 1'b1};
                            d.bitn     = 4'(q.bitn + 4'h1);
                            d.busy     = (q.bitn != csp_pkg::BYTE_BITS);
                        end
                    endcase
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.sda_s    <= 2'b11;
            q.op       <= csp_pkg::OP_START;
            q.div      <= csp_pkg::DIV_RESET;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.scl_o      = 1'b0;
    assign bus.scl_oe_n   = q.scl_oe_n;
    assign bus.sda_m_o    = 1'b0;
    assign bus.sda_m_oe_n = q.sda_oe_n;
    assign prdata         = q.prdata;
    assign pready         = q.pready;
    assign pslverr        = q.pslverr;

endmodule : csp_host

// File: verif/csp_link_sva.sv
// checker for the two-wire link between controller and camera port
// assumes it watches the resolved lines and all open-drain enables of one link
module csp_link_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link lines
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_m_o,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_o,
    input wire logic sda_s_oe_n,
    input wire logic scl,
    input wire logic sda,
    // address strap
    input wire logic address_select_pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // bus event tracking
    // ------------------------------------------------------------
    logic       scl_q;
    logic       sda_q;
    logic       nomatch_q;
    logic [3:0] bitn_q;
    logic [7:0] sh_q;
    logic       rise;
    logic       start;
    logic       stop;
    logic       match;
    assign rise  = scl & ~scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop  = scl & scl_q & ~sda_q & sda;
    assign match = (sh_q[7:3] == csp_pkg::DAB_FIXED) && (sh_q[2] == ~address_select_pin)
                   && (sh_q[1] == address_select_pin);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            bitn_q    <= 4'h0;
            sh_q      <= 8'h00;
            nomatch_q <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start || stop) begin
                bitn_q    <= 4'h0;
                nomatch_q <= 1'b0;
            end else if (rise) begin
                sh_q <= {sh_q[6:0], sda};
                if (bitn_q != 4'hF) bitn_q <= bitn_q + 4'h1;
                if (bitn_q == 4'h8 && !match) nomatch_q <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_od_levels: assert property (!scl_o && !sda_m_o && !sda_s_o)
        else $error("driver value not low");
    a_idle_high: assert property ($rose(presetn) |-> scl && sda)
        else $error("lines not idle high after reset");
    a_scl_by_host: assert property (scl == scl_oe_n)
        else $error("clock line not set by host alone");
    a_dev_scl_low: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("device data change with clock high");
    a_ack_held: assert property ($fell(sda_s_oe_n) |-> ##[1:64] ($rose(scl) && !sda_s_oe_n))
        else $error("device low not held into clock high");
    a_addr_ack: assert property (rise && bitn_q == 4'h8 |-> sda_s_oe_n == !match)
        else $error("address acknowledge wrong");
    a_addr_quiet: assert property (scl && !rise && bitn_q >= 4'h1 && bitn_q <= 4'h8 |-> sda_s_oe_n)
        else $error("device drives during address byte");
    a_mismatch_quiet: assert property (nomatch_q |-> sda_s_oe_n)
        else $error("device drives after foreign address");
    a_stop_release: assert property (stop |=> sda_s_oe_n [*8])
        else $error("device drives after stop");
endmodule : csp_link_sva

// File: verif/camera_serial_register_port_test.sv
// bench: apb-driven controller and camera port joined by one link
// assumes csp_pkg, csp_bus_if, csp_host, csp_dev and the checker compiled first
module camera_serial_register_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals and models
    // ------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        asp = 1'b1;
    logic        reg_wr;
    logic        reg_rd;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  mem [64];
    logic [31:0] rd;
    logic        e;
    int          bad_count = 0;
    int          checked = 0;
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (reg_wr) mem[reg_addr] <= reg_wdata;
    assign reg_rdata = mem[reg_addr];
    csp_bus_if u_csp_bus_if ();
    csp_host u_csp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(u_csp_bus_if));
    csp_dev u_csp_dev (.pclk(pclk), .presetn(presetn), .bus(u_csp_bus_if),
        .address_select_pin(asp), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    csp_link_sva u_csp_link_sva (.pclk(pclk), .presetn(presetn),
        .scl_o(u_csp_bus_if.scl_o), .scl_oe_n(u_csp_bus_if.scl_oe_n),
        .sda_m_o(u_csp_bus_if.sda_m_o), .sda_m_oe_n(u_csp_bus_if.sda_m_oe_n),
        .sda_s_o(u_csp_bus_if.sda_s_o), .sda_s_oe_n(u_csp_bus_if.sda_s_oe_n),
        .scl(u_csp_bus_if.scl), .sda(u_csp_bus_if.sda), .address_select_pin(asp));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic die();
        bad_count++;
        $display("mismatch at %0t: wait timed out", $time);
        wrap_up();
    endtask : die
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) die();
        r  = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic [1:0] op, input logic nk, input logic [7:0] d,
                       output logic [31:0] st);
        logic er;
        int   n;
        n = 0;
        apb(1'b1, csp_pkg::OFS_CMD, {16'h0000, d, 5'h00, nk, op}, st, er);
        do begin
            apb(1'b0, csp_pkg::OFS_STAT, 32'h0000_0000, st, er);
            n++;
        end while (st[csp_pkg::STAT_BUSY] !== 1'b0 && n < 400);
        if (n >= 400) die();
    endtask : cmd
    task automatic go();
        logic [31:0] st;
        cmd(csp_pkg::OP_START, 1'b0, 8'h00, st);
    endtask : go
    task automatic halt();
        logic [31:0] st;
        cmd(csp_pkg::OP_STOP, 1'b0, 8'h00, st);
    endtask : halt
    task automatic wb(input logic [7:0] b, input logic nak);
        logic [31:0] st;
        cmd(csp_pkg::OP_WRITE, 1'b0, b, st);
        chk({7'h00, st[csp_pkg::STAT_NACK]}, {7'h00, nak});
    endtask : wb
    task automatic rb(input logic nk, input logic [7:0] exp);
        logic [31:0] st;
        cmd(csp_pkg::OP_READ, nk, 8'h00, st);
        chk(st[7:0], exp);
    endtask : rb
    function automatic logic [7:0] dab(input logic rw);
        return {csp_pkg::DAB_FIXED, ~asp, asp, rw};
    endfunction : dab
    function automatic logic [7:0] f(input logic [5:0] i);
        return {2'b00, i} ^ 8'hC3;
    endfunction : f
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 64; i++) mem[i] = f(6'(i));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, csp_pkg::OFS_DIV, 32'h0000_0000, rd, e);
        chk(rd[7:0], csp_pkg::DIV_RESET[7:0]);
        apb(1'b0, 8'h0C, 32'h0000_0000, rd, e);
        chk({7'h00, e}, 8'h01);
        go();
        wb(dab(1'b0), 1'b0);
        wb(8'h05, 1'b0);
        wb(8'hA5, 1'b0);
        wb(8'h06, 1'b0);
        wb(8'h5A, 1'b0);
        halt();
        chk(mem[5], 8'hA5);
        chk(mem[6], 8'h5A);
        go();
        wb(dab(1'b0), 1'b0);
        wb(8'h64, 1'b0);
        wb(8'h11, 1'b0);
        wb(8'h22, 1'b0);
        wb(8'h10, 1'b0);
        wb(8'h33, 1'b0);
        wb(8'h44, 1'b0);
        halt();
        chk(mem[6'h24], 8'h11);
        chk(mem[6'h25], 8'h22);
        chk(mem[6'h26], f(6'h26));
        chk(mem[6'h10], 8'h33);
        chk(mem[6'h11], 8'h44);
        go();
        wb(dab(1'b0), 1'b0);
        wb(8'h05, 1'b0);
        go();
        wb(dab(1'b1), 1'b0);
        rb(1'b1, 8'hA5);
        go();
        wb(dab(1'b1), 1'b0);
        rb(1'b1, 8'hA5);
        halt();
        go();
        wb(dab(1'b0), 1'b0);
        wb(8'h69, 1'b0);
        go();
        wb(dab(1'b1), 1'b0);
        rb(1'b0, f(6'h29));
        rb(1'b0, f(6'h2A));
        rb(1'b1, f(6'h00));
        halt();
        go();
        wb(dab(1'b0) ^ 8'h06, 1'b1);
        wb(8'h05, 1'b1);
        wb(8'h00, 1'b1);
        halt();
        chk(mem[5], 8'hA5);
        asp <= 1'b0;
        repeat (4) @(posedge pclk);
        go();
        wb(dab(1'b0), 1'b0);
        wb(8'h70, 1'b0);
        wb(8'h66, 1'b0);
        go();
        wb(dab(1'b0), 1'b0);
        wb(8'h07, 1'b0);
        wb(8'h77, 1'b0);
        halt();
        chk(mem[6'h30], 8'h66);
        chk(mem[6'h31], f(6'h31));
        chk(mem[7], 8'h77);
        wrap_up();
    end
endmodule : camera_serial_register_port_test
